// ### cax_axis_setup.sv
// axis setup: commutation routing, drive enables, encoders, hall inputs, register slave
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "cax_defs.svh"

module cax_axis_setup (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire cax_pkg::cax_enc_pins_type encPins,
   input wire logic [`CAX_DIG_INPUTS-1:0] digitalIn,
   input wire logic watchdogFire,
   input wire logic [7:0] posErrExceed,
   output logic [7:0] drive_enable_out,
   output cax_pkg::cax_dac_route_type [7:0] dacRoute,
   output logic irq
);
   // ****************
   // functions
   // ****************
   function automatic logic [3:0] countBits(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++)
         n = n + {3'h0, v[i]};
      return n;
   endfunction

   // index of the k-th set bit counted from axis A upward
   function automatic logic [2:0] kthSet(input logic [7:0] v, input logic [3:0] k);
      logic [3:0] seen;
      logic [2:0] idx;
      seen = 4'h0;
      idx = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (v[i]) begin
            if (seen == k)
               idx = i[2:0];
            seen = seen + 4'h1;
         end
      end
      return idx;
   endfunction

   // every commutated axis must stay below the standard count
   function automatic logic selLegal(input logic [7:0] sel, input logic [3:0] build);
      logic [3:0] std;
      logic ok;
      std = build - countBits(sel);
      ok = (build >= 4'h1) && (build <= 4'h8) && (countBits(sel) <= build);
      for (int i = 0; i < 8; i++)
         if (sel[i] && (i[3:0] >= std))
            ok = 1'b0;
      return ok;
   endfunction

   // three consecutive inputs inside one bank
   function automatic logic hallLegal(input logic [6:0] first);
      return (first >= 7'd1 && first <= 7'd6) || (first >= 7'd17 && first <= 7'd78)
         || (first >= 7'd81 && first <= 7'd94);
   endfunction

   // hall code to one of six sectors, 7 marks an illegal code
   function automatic logic [2:0] hallSector(input logic [2:0] h);
      unique case (h)
         3'h1: return 3'h0;
         3'h3: return 3'h1;
         3'h2: return 3'h2;
         3'h6: return 3'h3;
         3'h4: return 3'h4;
         3'h5: return 3'h5;
         default: return 3'h7;
      endcase
   endfunction

   // ****************
   // registers
   // ****************
   logic [7:0] commut_reg;
   logic [3:0] build_reg;
   logic [7:0] driveOn_reg;
   logic [7:0] trip3_reg;
   logic [15:0] polarity_reg;
   logic [15:0] encMode_reg;
   logic [7:0] hallPres_reg;
   logic [23:0] phManual_reg;
   logic [23:0] phase_reg;
   logic [`CAX_IRQ_WIDTH-1:0] irqStat_reg;
   logic [`CAX_IRQ_WIDTH-1:0] irqEn_reg;
   logic [6:0] hallFirst_reg [8];
   logic [31:0] readdata_reg;
   logic waitreq_reg;
   logic irq_reg;
   logic [7:0] driveOut_reg;
   cax_pkg::cax_dac_route_type [7:0] route_reg;
   logic [31:0] position [8];
   logic [31:0] indexPos [8];

   // ****************
   // bus decode
   // ****************
   wire access = (avs_read || avs_write) && waitreq_reg;
   wire wrTake = avs_write && !waitreq_reg;
   wire [7:0] wrData8 = avs_writedata[7:0];
   wire [2:0] slot = avs_address[4:2];
   wire hitCommut = wrTake && avs_address == `CAX_OFS_COMMUT;
   wire hitBuild = wrTake && avs_address == `CAX_OFS_BUILD;
   wire hitOff = wrTake && avs_address == `CAX_OFS_DRVOFF;
   wire hitOn = wrTake && avs_address == `CAX_OFS_DRVON;
   wire hitTrip = wrTake && avs_address == `CAX_OFS_TRIP3;
   wire hitPol = wrTake && avs_address == `CAX_OFS_POLARITY;
   wire hitEnc = wrTake && avs_address == `CAX_OFS_ENCMODE;
   wire hitPres = wrTake && avs_address == `CAX_OFS_HALLPRES;
   wire hitManual = wrTake && avs_address == `CAX_OFS_PHMANUAL;
   wire hitClr = wrTake && avs_address == `CAX_OFS_IRQCLR;
   wire hitEn = wrTake && avs_address == `CAX_OFS_IRQEN;
   wire hitHall = wrTake && avs_address[7:5] == 3'h2;
   wire commutOk = selLegal(wrData8, build_reg);
   wire buildOk = selLegal(commut_reg, avs_writedata[3:0]);
   wire hallOk = hallLegal(avs_writedata[6:0]);
   wire reject = (hitCommut && !commutOk) || (hitBuild && !buildOk) || (hitHall && !hallOk);

   // ****************
   // commutation routing
   // ****************
   wire [3:0] commutCount = countBits(commut_reg);
   wire [3:0] stdAxes = build_reg - commutCount;
   cax_pkg::cax_dac_route_type [7:0] route_next;

   always_comb begin
      for (int d = 0; d < 8; d++) begin
         route_next[d] = '0;
         if (d[3:0] < stdAxes) begin
            route_next[d].valid = 1'b1;
            route_next[d].axis = d[2:0];
         end else if (d[3:0] < build_reg) begin
            route_next[d].valid = 1'b1;
            route_next[d].phase2 = 1'b1;
            route_next[d].axis = kthSet(commut_reg, d[3:0] - stdAxes);
         end
      end
   end

   // ****************
   // drive enable
   // ****************
   wire [7:0] tripHit = trip3_reg & posErrExceed;
   wire [7:0] offCause = (watchdogFire ? 8'hff : 8'h00) | tripHit | (hitOff ? wrData8 : 8'h00);
   wire [7:0] onSet = hitOn ? wrData8 : 8'h00;
   wire [7:0] driveOn_next = (driveOn_reg | onSet) & ~offCause;
   wire [7:0] dropped = driveOn_reg & offCause;
   wire [7:0] groupInv = {{4{polarity_reg[`CAX_POL_HIGH_BIT]}},
      {4{polarity_reg[`CAX_POL_LOW_BIT]}}};
   wire [7:0] axisInv = polarity_reg[`CAX_POL_AXINV_LSB +: 8];
   wire [7:0] invert = polarity_reg[`CAX_POL_PERAXIS_BIT] ? axisInv : groupInv;
   wire [7:0] driveOut_next = driveOn_next ^ invert;

   // ****************
   // encoders
   // ****************
   wire [7:0] diffMode = encMode_reg[`CAX_ENC_DIFF_LSB +: 8];
   wire [7:0] chA = encPins.aPos & ~(diffMode & encPins.aNeg);
   wire [7:0] chB = encPins.bPos & ~(diffMode & encPins.bNeg);
   wire [7:0] chI = encPins.iPos & ~(diffMode & encPins.iNeg);

   for (genvar g = 0; g < 8; g++) begin : gEnc
      cax_enc_decoder uDec (
         .clk(clk),
         .rst_n(rst_n),
         .chA(chA[g]),
         .chB(chB[g]),
         .index(chI[g]),
         .mode(cax_pkg::cax_enc_mode_type'({encMode_reg[g], diffMode[g]})),
         .position(position[g]),
         .indexPos(indexPos[g])
      );
   end

   // ****************
   // hall inputs and phase
   // ****************
   logic [23:0] phase_next;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         logic [2:0] sec;
         sec = hallSector(digitalIn[7'(hallFirst_reg[i] - 7'd1) +: 3]);
         phase_next[i*3 +: 3] = phase_reg[i*3 +: 3];
         if (!hallPres_reg[i])
            phase_next[i*3 +: 3] = phManual_reg[i*3 +: 3];
         else if (sec != 3'h7)
            phase_next[i*3 +: 3] = sec;
      end
   end

   // ****************
   // interrupt status
   // ****************
   wire [`CAX_IRQ_WIDTH-1:0] irqEvents = {watchdogFire, reject, dropped};
   wire [`CAX_IRQ_WIDTH-1:0] irqClr = hitClr ? avs_writedata[`CAX_IRQ_WIDTH-1:0] : '0;
   wire [`CAX_IRQ_WIDTH-1:0] irqStat_next = (irqStat_reg & ~irqClr) | irqEvents;
   wire [`CAX_IRQ_WIDTH-1:0] irqEn_next = hitEn ? avs_writedata[`CAX_IRQ_WIDTH-1:0] : irqEn_reg;

   // ****************
   // read mux
   // ****************
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0;
      if (avs_address[7:5] == 3'h2)
         rdMux = {25'h0, hallFirst_reg[slot]};
      else if (avs_address[7:5] == 3'h3)
         rdMux = position[slot];
      else if (avs_address[7:5] == 3'h4)
         rdMux = indexPos[slot];
      else begin
         unique case (avs_address)
            `CAX_OFS_COMMUT: rdMux = {24'h0, commut_reg};
            `CAX_OFS_BUILD: rdMux = {28'h0, build_reg};
            `CAX_OFS_STDAXES: rdMux = {28'h0, stdAxes};
            `CAX_OFS_DRVSTATE: rdMux = {24'h0, driveOn_reg};
            `CAX_OFS_TRIP3: rdMux = {24'h0, trip3_reg};
            `CAX_OFS_POLARITY: rdMux = {16'h0, polarity_reg};
            `CAX_OFS_ENCMODE: rdMux = {16'h0, encMode_reg};
            `CAX_OFS_HALLPRES: rdMux = {24'h0, hallPres_reg};
            `CAX_OFS_PHMANUAL: rdMux = {8'h0, phManual_reg};
            `CAX_OFS_PHASE: rdMux = {8'h0, phase_reg};
            `CAX_OFS_IRQSTAT: rdMux = {22'h0, irqStat_reg};
            `CAX_OFS_IRQEN: rdMux = {22'h0, irqEn_reg};
            `CAX_OFS_ROUTE: rdMux = route_reg[3:0];
            default: rdMux = 32'h0;
         endcase
      end
   end

   // ****************
   // bus slave and outputs
   // ****************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitreq_reg <= 1'b1;
         readdata_reg <= 32'h0;
         irq_reg <= 1'b0;
         driveOut_reg <= 8'h00;
         route_reg <= '0;
      end else begin
         waitreq_reg <= !access;
         if (access)
            readdata_reg <= rdMux;
         irq_reg <= |(irqStat_next & irqEn_next);
         driveOut_reg <= driveOut_next;
         route_reg <= route_next;
      end
   end

   // ****************
   // configuration state
   // ****************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         commut_reg <= 8'h00;
         build_reg <= `CAX_RST_BUILD;
         driveOn_reg <= 8'h00;
         trip3_reg <= 8'h00;
         polarity_reg <= 16'h0;
         encMode_reg <= 16'h0;
         hallPres_reg <= 8'h00;
         phManual_reg <= 24'h0;
         phase_reg <= 24'h0;
         irqStat_reg <= '0;
         irqEn_reg <= '0;
         for (int i = 0; i < 8; i++)
            hallFirst_reg[i] <= `CAX_RST_HALLFIRST;
      end else begin
         if (hitCommut && commutOk)
            commut_reg <= wrData8;
         if (hitBuild && buildOk)
            build_reg <= avs_writedata[3:0];
         if (hitTrip)
            trip3_reg <= wrData8;
         if (hitPol)
            polarity_reg <= avs_writedata[15:0];
         if (hitEnc)
            encMode_reg <= avs_writedata[15:0];
         if (hitPres)
            hallPres_reg <= wrData8;
         if (hitManual)
            phManual_reg <= avs_writedata[23:0];
         if (hitHall && hallOk)
            hallFirst_reg[slot] <= avs_writedata[6:0];
         driveOn_reg <= driveOn_next;
         phase_reg <= phase_next;
         irqStat_reg <= irqStat_next;
         irqEn_reg <= irqEn_next;
      end
   end

   assign avs_readdata = readdata_reg;
   assign avs_waitrequest = waitreq_reg;
   assign drive_enable_out = driveOut_reg;
   assign dacRoute = route_reg;
   assign irq = irq_reg;
endmodule

// ### cax_defs.svh
// offsets, field positions, reset values and sizes for the commutation axis block
`ifndef CAX_DEFS_SVH
`define CAX_DEFS_SVH
`define CAX_AXES 8
`define CAX_OFS_COMMUT 8'h00
`define CAX_OFS_BUILD 8'h04
`define CAX_OFS_STDAXES 8'h08
`define CAX_OFS_DRVOFF 8'h0c
`define CAX_OFS_DRVON 8'h10
`define CAX_OFS_DRVSTATE 8'h14
`define CAX_OFS_TRIP3 8'h18
`define CAX_OFS_POLARITY 8'h1c
`define CAX_OFS_ENCMODE 8'h20
`define CAX_OFS_HALLPRES 8'h24
`define CAX_OFS_PHMANUAL 8'h28
`define CAX_OFS_PHASE 8'h2c
`define CAX_OFS_IRQSTAT 8'h30
`define CAX_OFS_IRQCLR 8'h34
`define CAX_OFS_IRQEN 8'h38
`define CAX_OFS_ROUTE 8'h3c
`define CAX_OFS_HALLFIRST 8'h40
`define CAX_OFS_POSITION 8'h60
`define CAX_OFS_INDEXPOS 8'h80
`define CAX_RST_BUILD 4'h8
`define CAX_POL_LOW_BIT 0
`define CAX_POL_HIGH_BIT 1
`define CAX_POL_PERAXIS_BIT 2
`define CAX_POL_AXINV_LSB 8
`define CAX_ENC_DIFF_LSB 8
`define CAX_IRQ_REJECT_BIT 8
`define CAX_IRQ_WDOG_BIT 9
`define CAX_IRQ_WIDTH 10
`define CAX_DIG_INPUTS 96
`define CAX_RST_HALLFIRST 7'h01
`endif

// ### cax_pkg.sv
// types shared by the commutation axis block
package cax_pkg;
   typedef struct packed {
      logic valid;
      logic phase2;
      logic [2:0] spare;
      logic [2:0] axis;
   } cax_dac_route_type;

   typedef struct packed {
      logic [7:0] aPos;
      logic [7:0] aNeg;
      logic [7:0] bPos;
      logic [7:0] bNeg;
      logic [7:0] iPos;
      logic [7:0] iNeg;
   } cax_enc_pins_type;

   typedef struct packed {
      logic pulseDir;
      logic diff;
   } cax_enc_mode_type;
endpackage

// ### cax_enc_decoder.sv
// one axis of encoder decoding: quadrature or pulse and direction, with index latch
`timescale 1ns/100ps
module cax_enc_decoder (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic chA,
   input wire logic chB,
   input wire logic index,
   input wire cax_pkg::cax_enc_mode_type mode,
   output logic [31:0] position,
   output logic [31:0] indexPos
);
   logic prevA_reg;
   logic prevB_reg;
   logic prevI_reg;
   logic [31:0] pos_reg;
   logic [31:0] idx_reg;

   // ****************
   // step decode
   // ****************
   wire aMoved = chA ^ prevA_reg;
   wire bMoved = chB ^ prevB_reg;
   // single edge only; a lone faulty channel alternates up and down
   wire quadStep = aMoved ^ bMoved;
   wire quadUp = aMoved ? (chA ^ chB) : ~(chA ^ chB);
   wire pdStep = chA & ~prevA_reg;
   wire step = mode.pulseDir ? pdStep : quadStep;
   wire up = mode.pulseDir ? chB : quadUp;
   wire [31:0] pos_next = up ? pos_reg + 32'h1 : pos_reg - 32'h1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prevA_reg <= 1'b0;
         prevB_reg <= 1'b0;
         prevI_reg <= 1'b0;
         pos_reg <= 32'h0;
         idx_reg <= 32'h0;
      end else begin
         prevA_reg <= chA;
         prevB_reg <= chB;
         prevI_reg <= index;
         if (step)
            pos_reg <= pos_next;
         if (index && !prevI_reg)
            idx_reg <= pos_reg;
      end
   end

   assign position = pos_reg;
   assign indexPos = idx_reg;
endmodule

// ### cax_axis_setup_asserts.sv
// assertion checker for the commutation axis block
`timescale 1ns/100ps
module cax_axis_setup_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic avs_write,
   input wire logic watchdogFire,
   input wire logic [7:0] posErrExceed,
   input wire logic [7:0] drive_enable_out,
   input wire cax_pkg::cax_dac_route_type [7:0] dacRoute
);
   // ****************************************
   // route shape helpers
   // ****************************************
   logic stdOk, orderOk, topOk, tailOk, seen;
   logic [2:0] first;
   always_comb begin
      stdOk = 1'b1;
      orderOk = 1'b1;
      topOk = 1'b1;
      tailOk = 1'b1;
      seen = 1'b0;
      first = 3'h0;
      for (int d = 0; d < 8; d++) begin
         if (dacRoute[d].valid && !dacRoute[d].phase2 && dacRoute[d].axis != 3'(d)) stdOk = 1'b0;
         if (d > 0 && dacRoute[d].valid && !dacRoute[d-1].valid) tailOk = 1'b0;
         if (d > 0 && dacRoute[d].phase2 && dacRoute[d-1].phase2
             && dacRoute[d].axis <= dacRoute[d-1].axis) orderOk = 1'b0;
         if (dacRoute[d].phase2) begin
            if (!seen) first = 3'(d);
            seen = 1'b1;
            if (dacRoute[d].axis >= first) topOk = 1'b0;
         end else if (seen && dacRoute[d].valid) begin
            topOk = 1'b0;
         end
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_first_phase: assert property (stdOk) else $error("first phase misrouted");
   a_second_order: assert property (orderOk) else $error("second phases out of order");
   a_top_reserved: assert property (topOk) else $error("top axis commutated");
   a_route_tail: assert property (tailOk) else $error("gap in routed outputs");
   a_dac0_std: assert property ($past(rst_n) |-> dacRoute[0].valid && !dacRoute[0].phase2)
      else $error("output 0 not axis A");
   a_route_cause: assert property ($changed(dacRoute) |-> !$past(rst_n) || !$past(rst_n, 2)
      || $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
      else $error("route changed without write");
   a_enable_cause: assert property ($changed(drive_enable_out) |-> !$past(rst_n)
      || $past(watchdogFire) || $past(|posErrExceed) || $past(|posErrExceed, 2)
      || $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
      else $error("enable changed without cause");
   a_wdog_off: assert property (watchdogFire ##1 watchdogFire |=> $stable(drive_enable_out))
      else $error("enable moved under watchdog");
endmodule
bind cax_axis_setup cax_axis_setup_asserts u_chk (.clk(clk), .rst_n(rst_n),
   .avs_write(avs_write), .watchdogFire(watchdogFire), .posErrExceed(posErrExceed),
   .drive_enable_out(drive_enable_out), .dacRoute(dacRoute));

// ### cax_far_model.sv
// far-side model: encoders on every axis and one set of hall sensors
`timescale 1ns/100ps
module cax_far_model #(
   parameter int HALL_BIT = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] step,
   input wire logic dir,
   input wire logic [7:0] pulseAx,
   input wire logic [7:0] glitch,
   input wire logic [2:0] hallCode,
   output cax_pkg::cax_enc_pins_type encPins,
   output logic [95:0] digitalIn
);
   logic [1:0] phase_reg [8];
   logic [7:0] glitch_reg, chA, chB;
   logic [95:0] noise_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= '{default: 2'h0};
         glitch_reg <= 8'h00;
         noise_reg <= {48{2'b01}};
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (step[i]) phase_reg[i] <= dir ? phase_reg[i] + 2'h1 : phase_reg[i] - 2'h1;
         end
         glitch_reg <= glitch_reg ^ glitch;
         noise_reg <= ~noise_reg;
      end
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         chA[i] = (pulseAx[i] ? phase_reg[i][0] : ^phase_reg[i]) ^ glitch_reg[i];
         chB[i] = pulseAx[i] ? dir : phase_reg[i][1];
      end
   end
   assign encPins = '{aPos: chA, aNeg: ~chA, bPos: chB, bNeg: ~chB, iPos: 8'h00, iNeg: 8'hff};
   always_comb begin
      digitalIn = noise_reg;
      digitalIn[HALL_BIT +: 3] = hallCode;
   end
endmodule

// ### tb.sv
// self-checking testbench for the commutation axis block
`timescale 1ns/100ps
`include "cax_defs.svh"
module tb;
   logic clk, rst_n, avs_read, avs_write, avs_waitrequest, watchdogFire, irq, dir, ok;
   logic [7:0] avs_address, posErrExceed, drive_enable_out, step, pulseAx, glitch, m, mo;
   logic [31:0] avs_writedata, avs_readdata, man;
   logic [2:0] hallCode;
   logic [95:0] digitalIn;
   logic [63:0] r;
   cax_pkg::cax_enc_pins_type encPins;
   cax_pkg::cax_dac_route_type [7:0] dacRoute;
   logic [31:0] expq [$];
   integer seed;
   int fails, n_compared, b, bo;
   cax_axis_setup u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .encPins(encPins),
      .digitalIn(digitalIn), .watchdogFire(watchdogFire), .posErrExceed(posErrExceed),
      .drive_enable_out(drive_enable_out), .dacRoute(dacRoute), .irq(irq));
   cax_far_model u_far (.clk(clk), .rst_n(rst_n), .step(step), .dir(dir), .pulseAx(pulseAx),
      .glitch(glitch), .hallCode(hallCode), .encPins(encPins), .digitalIn(digitalIn));
   // ****************************************
   // checking and bus tasks
   // ****************************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 40) begin
         fails++;
         complete_run();
      end
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   function automatic logic [63:0] route_exp(input int b, input logic [7:0] m);
      int n, k;
      logic [63:0] q;
      n = $countones(m);
      k = 0;
      q = '0;
      for (int d = 0; d < 8; d++) begin
         if (d < b - n) q[d*8 +: 8] = {4'h8, 1'b0, 3'(d)};
         if (m[d]) begin
            q[(b-n+k)*8 +: 8] = {4'hc, 1'b0, 3'(d)};
            k++;
         end
      end
      return q;
   endfunction
   always @(posedge clk) begin
      if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, expq.pop_front());
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [2:0] codes [6];
      codes = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
      seed = 32'hd15c;
      {rst_n, avs_read, avs_write, avs_address, avs_writedata, watchdogFire} = '0;
      {posErrExceed, step, dir, pulseAx, glitch, hallCode} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check(dacRoute, route_exp(8, 8'h00));
      rd(`CAX_OFS_BUILD, 32'h8);
      rd(`CAX_OFS_HALLFIRST, 32'h1);
      bus(1'b1, `CAX_OFS_BUILD, 32'h7);
      bus(1'b1, `CAX_OFS_COMMUT, 32'h05);
      r = route_exp(7, 8'h05);
      rd(`CAX_OFS_STDAXES, 32'h5);
      check(dacRoute, r);
      rd(`CAX_OFS_ROUTE, r[31:0]);
      $display("test seven axis done");
      bo = 7;
      mo = 8'h05;
      for (int i = 0; i < 24; i++) begin
         b = 1 + ($unsigned($random(seed)) % 8);
         bus(1'b1, `CAX_OFS_BUILD, 32'(b));
         if ($countones(mo) <= b && (mo >> (b - $countones(mo))) == 8'h0) bo = b;
         bus(1'b1, `CAX_OFS_IRQCLR, 32'h3ff);
         m = 8'($random(seed)) & (i[0] ? 8'hff : 8'h07);
         ok = $countones(m) <= bo && (m >> (bo - $countones(m))) == 8'h0;
         bus(1'b1, `CAX_OFS_COMMUT, {24'h0, m});
         if (ok) mo = m;
         rd(`CAX_OFS_COMMUT, {24'h0, mo});
         rd(`CAX_OFS_IRQSTAT, {23'h0, !ok, 8'h0});
         check(dacRoute, route_exp(bo, mo));
      end
      $display("test random commutation done");
      bus(1'b1, `CAX_OFS_IRQEN, 32'h3ff);
      bus(1'b1, `CAX_OFS_DRVON, 32'hff);
      check(drive_enable_out, 8'hff);
      bus(1'b1, `CAX_OFS_DRVOFF, 32'h01);
      @(posedge clk);
      check({drive_enable_out, irq}, {8'hfe, 1'b1});
      bus(1'b1, `CAX_OFS_IRQCLR, 32'h3ff);
      bus(1'b1, `CAX_OFS_IRQEN, 32'h0);
      watchdogFire <= 1'b1;
      repeat (2) @(posedge clk);
      watchdogFire <= 1'b0;
      repeat (2) @(posedge clk);
      check({drive_enable_out, irq}, 9'h0);
      rd(`CAX_OFS_IRQSTAT, 32'h2fe);
      bus(1'b1, `CAX_OFS_IRQEN, 32'h3ff);
      @(posedge clk);
      check(irq, 1'b1);
      bus(1'b1, `CAX_OFS_TRIP3, 32'h04);
      bus(1'b1, `CAX_OFS_DRVON, 32'hff);
      posErrExceed <= 8'h06;
      repeat (3) @(posedge clk);
      check(drive_enable_out, 8'hfb);
      posErrExceed <= 8'h00;
      rd(`CAX_OFS_DRVSTATE, 32'hfb);
      bus(1'b1, `CAX_OFS_POLARITY, 32'h1);
      @(posedge clk);
      check(drive_enable_out, 8'hf4);
      bus(1'b1, `CAX_OFS_POLARITY, 32'h8004);
      @(posedge clk);
      check(drive_enable_out, 8'h7b);
      $display("test drive enable done");
      bus(1'b1, `CAX_OFS_ENCMODE, 32'h0801);
      pulseAx <= 8'h01;
      for (int i = 0; i < 14; i++) begin
         dir <= (i < 10);
         step <= 8'h0b;
         @(posedge clk);
         step <= 8'h00;
         repeat (3) @(posedge clk);
      end
      rd(`CAX_OFS_POSITION, 32'd3);
      rd(`CAX_OFS_POSITION + 8'h04, 32'd6);
      rd(`CAX_OFS_POSITION + 8'h0c, 32'd6);
      for (int i = 0; i < 2; i++) begin
         glitch <= 8'h04;
         @(posedge clk);
         glitch <= 8'h00;
         repeat (3) @(posedge clk);
         rd(`CAX_OFS_POSITION + 8'h08, 32'(1 - i));
      end
      $display("test encoder done");
      man = $random(seed) & 32'hffffff;
      bus(1'b1, `CAX_OFS_PHMANUAL, man);
      bus(1'b1, `CAX_OFS_HALLPRES, 32'h10);
      bus(1'b1, `CAX_OFS_HALLFIRST + 8'h10, 32'd17);
      bus(1'b1, `CAX_OFS_HALLFIRST + 8'h10, 32'd79);
      rd(`CAX_OFS_HALLFIRST + 8'h10, 32'd17);
      for (int i = 0; i < 6; i++) begin
         hallCode <= codes[i];
         repeat (4) @(posedge clk);
         rd(`CAX_OFS_PHASE, (man & 32'hff8fff) | 32'(i << 12));
      end
      $display("test hall done");
      complete_run();
   end
endmodule
